// ### logic/cbsc_pkg.sv
/*
  Constants for the card bridge system control fields, bits 21 down to 5.
  Assumes a 100 MHz system clock and one socket per configuration function.
*/
package cbsc_pkg;

  // Offset of the system control register in configuration space.
  localparam logic [7:0]  CBSC_SYSCTL_OFFSET = 8'h80;
  // Value of the whole register after reset.
  localparam logic [31:0] CBSC_SYSCTL_RESET  = 32'h0800_9060;

  // Field positions.
  localparam int CBSC_BIT_GUARD    = 21;
  localparam int CBSC_BIT_VIDEO    = 20;
  localparam int CBSC_BIT_BURST_DN = 15;
  localparam int CBSC_BIT_BURST_UP = 14;
  localparam int CBSC_BIT_ACCESS   = 13;
  localparam int CBSC_BIT_ONE      = 12;
  localparam int CBSC_BIT_STREAM   = 11;
  localparam int CBSC_BIT_UP_BUSY  = 10;
  localparam int CBSC_BIT_DN_BUSY  = 9;
  localparam int CBSC_BIT_PROBE    = 8;
  localparam int CBSC_BIT_ZERO     = 7;
  localparam int CBSC_BIT_LOW_PWR  = 6;
  localparam int CBSC_BIT_ID_LOCK  = 5;

  // Number of sockets, one per function.
  localparam int CBSC_SOCKETS = 2;

  // Settling delays and the clock period, in nanoseconds.
  localparam int CBSC_CLK_PERIOD_NS     = 10;
  localparam int CBSC_PWR_UP_SETTLE_NS  = 20000;
  localparam int CBSC_PWR_DN_SETTLE_NS  = 10000;
  // Least times, so the cycle counts round up.
  localparam int CBSC_PWR_UP_CYCLES =
    (CBSC_PWR_UP_SETTLE_NS + CBSC_CLK_PERIOD_NS - 1) / CBSC_CLK_PERIOD_NS;
  localparam int CBSC_PWR_DN_CYCLES =
    (CBSC_PWR_DN_SETTLE_NS + CBSC_CLK_PERIOD_NS - 1) / CBSC_CLK_PERIOD_NS;

endpackage : cbsc_pkg

// ### logic/cbsc_socket.sv
/*
  Per-socket status tracking: switch stream, settling delays, probe, activity.
  Assumes all event inputs are single-cycle pulses on sys_clk.
*/
`timescale 1ns/1ps
module cbsc_socket #(
  parameter int UP_CYCLES = cbsc_pkg::CBSC_PWR_UP_CYCLES,
  parameter int DN_CYCLES = cbsc_pkg::CBSC_PWR_DN_CYCLES
) (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Context clear from the bus reset while power events are off.
  input  wire logic ctx_clear,
  // Power switch events.
  input  wire logic power_req,
  input  wire logic power_up_dir,
  input  wire logic stream_done,
  // Probe and access events.
  input  wire logic probe_start,
  input  wire logic probe_done,
  input  wire logic card_access,
  input  wire logic flag_read_clear,
  // Status flags.
  output logic      switch_stream_busy,
  output logic      power_on_settle_busy,
  output logic      power_off_settle_busy,
  output logic      card_probe_busy,
  output logic      socket_access_flag
);
  import cbsc_pkg::*;

  localparam int MAX_CYC = (UP_CYCLES > DN_CYCLES) ? UP_CYCLES : DN_CYCLES;
  localparam int CNT_W   = $clog2(MAX_CYC + 1);
  localparam logic [CNT_W-1:0] UP_LAST = CNT_W'(UP_CYCLES - 1);
  localparam logic [CNT_W-1:0] DN_LAST = CNT_W'(DN_CYCLES - 1);

  // The counters need at least one cycle of delay.
  if (UP_CYCLES < 1 || DN_CYCLES < 1) begin : g_bad_counts
    $error("cbsc_socket: settle counts must be at least one");
  end

  logic             pending_reg;   // Stream requested, not yet complete.
  logic             dir_reg;       // Direction of the requested change.
  logic [CNT_W-1:0] cnt_reg;       // Settling delay counter.
  logic             up_start;      // Power-up stream has just finished.
  logic             dn_start;      // Power-down stream has just finished.
  logic             up_end;        // Power-up delay reaches terminal count.
  logic             dn_end;        // Power-down delay reaches terminal count.

  assign up_start = pending_reg & stream_done & dir_reg;
  assign dn_start = pending_reg & stream_done & ~dir_reg;
  assign up_end   = power_on_settle_busy & (cnt_reg == UP_LAST);
  assign dn_end   = power_off_settle_busy & (cnt_reg == DN_LAST);

  // Track the outstanding request; a new request wins over completion.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending_reg <= 1'b0;
      dir_reg     <= 1'b0;
    end else begin
      pending_reg <= power_req | (pending_reg & ~stream_done);
      if (power_req) begin
        dir_reg <= power_up_dir;
      end
    end
  end

  // Settling delay flags; the bus-reset context clear drops them.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_on_settle_busy  <= 1'b0;
      power_off_settle_busy <= 1'b0;
    end else if (ctx_clear) begin
      power_on_settle_busy  <= 1'b0;
      power_off_settle_busy <= 1'b0;
    end else begin
      // A fresh stream restarts the delay in its own direction.
      power_on_settle_busy  <= up_start | (power_on_settle_busy & ~up_end & ~dn_start);
      power_off_settle_busy <= dn_start | (power_off_settle_busy & ~dn_end & ~up_start);
    end
  end

  // One counter serves both delays, since only one runs at a time.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (up_start || dn_start) begin
      cnt_reg <= '0;
    end else if (power_on_settle_busy || power_off_settle_busy) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end else begin
      cnt_reg <= '0;
    end
  end

  // Stream busy covers the request and the delay that follows it.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      switch_stream_busy <= 1'b0;
    end else begin
      switch_stream_busy <= power_req | (pending_reg & ~stream_done) | up_start | dn_start
                          | (power_on_settle_busy & ~up_end & ~ctx_clear)
                          | (power_off_settle_busy & ~dn_end & ~ctx_clear);
    end
  end

  // Probe flag; a start in the same cycle as a finish or clear wins.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      card_probe_busy <= 1'b0;
    end else if (probe_start) begin
      card_probe_busy <= 1'b1;
    end else if (probe_done || ctx_clear) begin
      card_probe_busy <= 1'b0;
    end
  end

  // Activity flag; an access during the clearing read is kept.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      socket_access_flag <= 1'b0;
    end else begin
      socket_access_flag <= card_access | (socket_access_flag & ~flag_read_clear);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_up_go;
    up_start && !ctx_clear;
  endsequence
  sequence s_dn_go;
    dn_start && !ctx_clear;
  endsequence

  property p_access_set;
    card_access |=> socket_access_flag;
  endproperty
  a_access_set: assert property (p_access_set) else $error("access flag not set");

  property p_access_clear;
    flag_read_clear && !card_access |=> !socket_access_flag;
  endproperty
  a_access_clear: assert property (p_access_clear) else $error("access flag kept");

  property p_up_start;
    s_up_go |=> power_on_settle_busy && cnt_reg == '0 && switch_stream_busy;
  endproperty
  a_up_start: assert property (p_up_start) else $error("power-up delay not started");

  property p_dn_start;
    s_dn_go |=> power_off_settle_busy && !power_on_settle_busy && cnt_reg == '0;
  endproperty
  a_dn_start: assert property (p_dn_start) else $error("power-down delay not started");

  property p_up_end;
    $fell(power_on_settle_busy) && !$past(ctx_clear) && !$past(dn_start)
      |-> $past(cnt_reg) == UP_LAST;
  endproperty
  a_up_end: assert property (p_up_end) else $error("power-up delay length wrong");

  property p_stream;
    power_req |=> switch_stream_busy ##1 (switch_stream_busy || !pending_reg);
  endproperty
  a_stream: assert property (p_stream) else $error("stream busy dropped early");

  property p_probe;
    probe_start |=> card_probe_busy;
  endproperty
  a_probe: assert property (p_probe) else $error("probe flag not set");

  property p_ctx;
    ctx_clear && !probe_start |=> !power_on_settle_busy && !power_off_settle_busy
                                  && !card_probe_busy;
  endproperty
  a_ctx: assert property (p_ctx) else $error("context bits survive bus reset");

endmodule : cbsc_socket

// ### logic/cbsc_sysctl.sv
/*
  System control register, bits 21 down to 5, for a two-function card bridge.
  Assumes configuration strobes are one-cycle pulses on sys_clk, that the
  function number selects the socket, and that bus_reset_n is an async pin.
*/
`timescale 1ns/1ps

// How it works
// - Bit 21 disables socket supply guard.
// - Bit 20 tri-states card address lines.
// - Bits 19 to 16 read zero.
// - Bit 15 enables downstream read bursts.
// - Bit 14 enables upstream read bursts.
// - Bit 13 sets on access, clears on read.
// - Bit 12 always reads one.
// - Bit 7 always reads zero.
// - Bit 11 busy during stream and delay.
// - Bit 10 marks power-up settling delay.
// - Bit 9 marks power-down settling delay.
// - Bit 8 marks card probe running.
// - Bit 6 shared low energy enable.
// - Bit 5 locks identifier registers.
// - Sticky bits cleared by global reset only.
// - Context bits follow bus reset unless events.
// - Register sits at offset 80h, both functions.
module cbsc_sysctl #(
  parameter int UP_CYCLES = cbsc_pkg::CBSC_PWR_UP_CYCLES,
  parameter int DN_CYCLES = cbsc_pkg::CBSC_PWR_DN_CYCLES
) (
  // Clock and global reset.
  input  wire logic                              sys_clk,
  input  wire logic                              sys_rst,
  // Configuration access.
  input  wire logic                              cfg_rd,
  input  wire logic                              cfg_wr,
  input  wire logic                              cfg_func,
  input  wire logic [7:0]                        cfg_addr,
  input  wire logic [3:0]                        cfg_be,
  input  wire logic [31:0]                       cfg_wdata,
  output logic      [31:0]                       cfg_rdata,
  output logic                                   cfg_rvalid,
  // Bus reset pin and power event enable.
  input  wire logic                              bus_reset_n,
  input  wire logic                              pme_enable,
  // Socket events, one bit per socket.
  input  wire logic [cbsc_pkg::CBSC_SOCKETS-1:0] power_req,
  input  wire logic [cbsc_pkg::CBSC_SOCKETS-1:0] power_up_dir,
  input  wire logic [cbsc_pkg::CBSC_SOCKETS-1:0] stream_done,
  input  wire logic [cbsc_pkg::CBSC_SOCKETS-1:0] probe_start,
  input  wire logic [cbsc_pkg::CBSC_SOCKETS-1:0] probe_done,
  input  wire logic [cbsc_pkg::CBSC_SOCKETS-1:0] card_access,
  // Per-socket controls.
  output logic      [cbsc_pkg::CBSC_SOCKETS-1:0] supply_guard_disable,
  output logic      [cbsc_pkg::CBSC_SOCKETS-1:0] reduced_video_pins,
  // Shared controls.
  output logic                                   read_burst_down_enable,
  output logic                                   read_burst_up_enable,
  output logic                                   low_energy_enable,
  output logic                                   id_write_lock
);
  import cbsc_pkg::*;

  localparam int NS = CBSC_SOCKETS;

  // Function number picks one of two sockets.
  if (NS != 2) begin : g_bad_sockets
    $error("cbsc_sysctl: exactly two sockets are supported");
  end

  logic          rst_sync1_reg;    // First stage of the bus reset synchroniser.
  logic          rst_sync2_reg;    // Second stage, active high bus reset.
  logic          ctx_clear;        // Bus reset while power events are off.
  logic          hit;              // Access targets this register.
  logic          wr_hit;           // Write to this register.
  logic          wr_shared;        // Write allowed to shared bits.
  logic [NS-1:0] read_clear;       // Read from a socket's function.
  logic [NS-1:0] guard_reg;        // Supply guard disable per socket.
  logic [NS-1:0] video_reg;        // Reduced video pins per socket.
  logic          burst_dn_reg;     // Downstream burst enable.
  logic          burst_up_reg;     // Upstream burst enable.
  logic          low_pwr_reg;      // Low energy enable.
  logic          id_lock_reg;      // Identifier write lock.
  logic [31:0]   rdata_reg;        // Read data holding register.
  logic          rvalid_reg;       // Read answer strobe.
  logic [NS-1:0] stream_busy;      // Per-socket stream status.
  logic [NS-1:0] up_busy;          // Per-socket power-up delay status.
  logic [NS-1:0] dn_busy;          // Per-socket power-down delay status.
  logic [NS-1:0] probe_busy;       // Per-socket probe status.
  logic [NS-1:0] access_flag;      // Per-socket activity status.
  logic [31:0]   rdata_next;       // Read data for the addressed function.
  logic          sock;             // Socket addressed by this access.

  assign sock      = cfg_func;
  assign hit       = (cfg_addr == CBSC_SYSCTL_OFFSET);
  assign wr_hit    = cfg_wr & hit;
  assign wr_shared = wr_hit & ~cfg_func;
  assign ctx_clear = rst_sync2_reg & ~pme_enable;

  // Bus reset pin passes two flip-flops before anything reads it.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= ~bus_reset_n;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  // A read of this register clears only its own socket's activity flag.
  always_comb begin
    read_clear = '0;
    if (cfg_rd && hit) begin
      read_clear[sock] = 1'b1;
    end
  end

  // Per-socket controls; of the two resets only the global reset touches them.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      guard_reg <= {NS{CBSC_SYSCTL_RESET[CBSC_BIT_GUARD]}};
      video_reg <= {NS{CBSC_SYSCTL_RESET[CBSC_BIT_VIDEO]}};
    end else if (wr_hit && cfg_be[2]) begin
      guard_reg[sock] <= cfg_wdata[CBSC_BIT_GUARD];
      video_reg[sock] <= cfg_wdata[CBSC_BIT_VIDEO];
    end
  end

  // Shared controls in byte lane 1; function 1 writes are ignored.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      burst_dn_reg <= CBSC_SYSCTL_RESET[CBSC_BIT_BURST_DN];
      burst_up_reg <= CBSC_SYSCTL_RESET[CBSC_BIT_BURST_UP];
    end else if (wr_shared && cfg_be[1]) begin
      burst_dn_reg <= cfg_wdata[CBSC_BIT_BURST_DN];
      burst_up_reg <= cfg_wdata[CBSC_BIT_BURST_UP];
    end
  end

  // Shared controls in byte lane 0.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_pwr_reg <= CBSC_SYSCTL_RESET[CBSC_BIT_LOW_PWR];
      id_lock_reg <= CBSC_SYSCTL_RESET[CBSC_BIT_ID_LOCK];
    end else if (wr_shared && cfg_be[0]) begin
      low_pwr_reg <= cfg_wdata[CBSC_BIT_LOW_PWR];
      id_lock_reg <= cfg_wdata[CBSC_BIT_ID_LOCK];
    end
  end

  // One status tracker per socket.
  for (genvar i = 0; i < NS; i++) begin : g_sock
    cbsc_socket #(
      .UP_CYCLES (UP_CYCLES),
      .DN_CYCLES (DN_CYCLES)
    ) u_sock (
      .sys_clk               (sys_clk),
      .sys_rst               (sys_rst),
      .ctx_clear             (ctx_clear),
      .power_req             (power_req[i]),
      .power_up_dir          (power_up_dir[i]),
      .stream_done           (stream_done[i]),
      .probe_start           (probe_start[i]),
      .probe_done            (probe_done[i]),
      .card_access           (card_access[i]),
      .flag_read_clear       (read_clear[i]),
      .switch_stream_busy    (stream_busy[i]),
      .power_on_settle_busy  (up_busy[i]),
      .power_off_settle_busy (dn_busy[i]),
      .card_probe_busy       (probe_busy[i]),
      .socket_access_flag    (access_flag[i])
    );
  end

  // Assemble the register image for the addressed function.
  always_comb begin
    rdata_next = '0;
    if (hit) begin
      rdata_next[CBSC_BIT_GUARD]    = guard_reg[sock];
      rdata_next[CBSC_BIT_VIDEO]    = video_reg[sock];
      rdata_next[19:16]             = 4'h0;
      rdata_next[CBSC_BIT_BURST_DN] = burst_dn_reg;
      rdata_next[CBSC_BIT_BURST_UP] = burst_up_reg;
      rdata_next[CBSC_BIT_ACCESS]   = access_flag[sock];
      rdata_next[CBSC_BIT_ONE]      = 1'b1;
      rdata_next[CBSC_BIT_STREAM]   = stream_busy[sock];
      rdata_next[CBSC_BIT_UP_BUSY]  = up_busy[sock];
      rdata_next[CBSC_BIT_DN_BUSY]  = dn_busy[sock];
      rdata_next[CBSC_BIT_PROBE]    = probe_busy[sock];
      rdata_next[CBSC_BIT_ZERO]     = 1'b0;
      rdata_next[CBSC_BIT_LOW_PWR]  = low_pwr_reg;
      rdata_next[CBSC_BIT_ID_LOCK]  = id_lock_reg;
    end
  end

  // Read answer one cycle after the strobe; other offsets read zero.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg  <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= cfg_rd;
      if (cfg_rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign cfg_rdata              = rdata_reg;
  assign cfg_rvalid             = rvalid_reg;
  assign supply_guard_disable   = guard_reg;
  assign reduced_video_pins     = video_reg;
  assign read_burst_down_enable = burst_dn_reg;
  assign read_burst_up_enable   = burst_up_reg;
  assign low_energy_enable      = low_pwr_reg;
  assign id_write_lock          = id_lock_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_lane1_f0;
    cfg_wr && hit && !cfg_func && cfg_be[1];
  endsequence
  sequence s_wr_lane0_f0;
    cfg_wr && hit && !cfg_func && cfg_be[0];
  endsequence

  property p_reserved;
    cfg_rvalid |-> cfg_rdata[19:16] == 4'h0 && (cfg_rdata[12] || cfg_rdata == 32'h0)
                   && !cfg_rdata[7];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits wrong");

  property p_guard_wr;
    cfg_wr && hit && cfg_be[2] |=> supply_guard_disable[$past(cfg_func)] == $past(cfg_wdata[21])
                                   && reduced_video_pins[$past(cfg_func)] == $past(cfg_wdata[20]);
  endproperty
  a_guard_wr: assert property (p_guard_wr) else $error("socket control not written");

  property p_burst_wr;
    s_wr_lane1_f0 |=> read_burst_down_enable == $past(cfg_wdata[15])
                      && read_burst_up_enable == $past(cfg_wdata[14]);
  endproperty
  a_burst_wr: assert property (p_burst_wr) else $error("burst enables not written");

  property p_lane0_wr;
    s_wr_lane0_f0 |=> low_energy_enable == $past(cfg_wdata[6])
                      && id_write_lock == $past(cfg_wdata[5]);
  endproperty
  a_lane0_wr: assert property (p_lane0_wr) else $error("lane 0 controls not written");

  property p_func1_shared;
    cfg_wr && cfg_func |=> $stable(read_burst_down_enable) && $stable(read_burst_up_enable)
                           && $stable(low_energy_enable) && $stable(id_write_lock);
  endproperty
  a_func1_shared: assert property (p_func1_shared) else $error("function 1 wrote shared");

  property p_sticky;
    !cfg_wr ##0 ctx_clear |=> $stable(supply_guard_disable) && $stable(read_burst_up_enable)
                              && $stable(read_burst_down_enable) && $stable(id_write_lock);
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky bit moved on bus reset");

  property p_offset;
    cfg_wr && !hit |=> $stable(supply_guard_disable) && $stable(low_energy_enable)
                       && $stable(read_burst_down_enable);
  endproperty
  a_offset: assert property (p_offset) else $error("write at wrong offset took effect");

  property p_read_clears;
    cfg_rd && hit && !card_access[cfg_func] ##1 cfg_rd && hit && $stable(cfg_func)
      |=> !cfg_rdata[13];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("activity not cleared");

  property p_unmapped;
    cfg_rd && !hit |=> cfg_rvalid && cfg_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_no_answer;
    !cfg_rd |=> !cfg_rvalid;
  endproperty
  a_no_answer: assert property (p_no_answer) else $error("answer without read");

  property p_lane2_off;
    cfg_wr && !cfg_be[2] |=> $stable(supply_guard_disable) && $stable(reduced_video_pins);
  endproperty
  a_lane2_off: assert property (p_lane2_off) else $error("masked lane written");

  property p_image;
    cfg_rd && hit && !cfg_wr
      |=> cfg_rdata[15:14] == {read_burst_down_enable, read_burst_up_enable}
          && cfg_rdata[6:5] == {low_energy_enable, id_write_lock};
  endproperty
  a_image: assert property (p_image) else $error("shared bits misreported");

  property p_guard_image;
    cfg_rd && hit && !cfg_wr
      |=> cfg_rdata[21] == supply_guard_disable[$past(cfg_func)]
          && cfg_rdata[20] == reduced_video_pins[$past(cfg_func)];
  endproperty
  a_guard_image: assert property (p_guard_image) else $error("socket bits misreported");

  property p_sync;
    $fell(bus_reset_n) |-> ##2 rst_sync2_reg;
  endproperty
  a_sync: assert property (p_sync) else $error("bus reset not synchronised");

endmodule : cbsc_sysctl

// ### verif/test_cbsc_sysctl.sv
/*
  Self-checking bench for the system control fields, bits 21 down to 5.
  Assumes cbsc_pkg and the design files are compiled before this file.
*/
`timescale 1ns/1ps
module test_cbsc_sysctl;
  import cbsc_pkg::*;

  // Short settling counts keep the run brief.
  localparam int UP_N = 4;
  localparam int DN_N = 3;

  // One row of ordinary write cases with the image and outputs they should give.
  typedef struct {
    logic        func;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic [31:0] image;
    logic [7:0]  outs;
  } cbsc_row_t;

  logic        sys_clk      = 1'b0;   // System clock.
  logic        sys_rst      = 1'b1;   // Global reset.
  logic        cfg_rd       = 1'b0;   // Read strobe.
  logic        cfg_wr       = 1'b0;   // Write strobe.
  logic        cfg_func     = 1'b0;   // Function select.
  logic [7:0]  cfg_addr     = 8'h80;  // Register offset.
  logic [3:0]  cfg_be       = 4'hf;   // Byte enables.
  logic [31:0] cfg_wdata    = 32'h0;  // Write data.
  logic [31:0] cfg_rdata;             // Read data.
  logic        cfg_rvalid;            // Read answer.
  logic        bus_reset_n  = 1'b1;   // Bus reset pin.
  logic        pme_enable   = 1'b0;   // Power event enable.
  logic [1:0]  power_req    = 2'b00;  // Power change requests.
  logic [1:0]  power_up_dir = 2'b00;  // Power direction.
  logic [1:0]  stream_done  = 2'b00;  // Stream completions.
  logic [1:0]  probe_start  = 2'b00;  // Probe starts.
  logic [1:0]  probe_done   = 2'b00;  // Probe ends.
  logic [1:0]  card_access  = 2'b00;  // Card accesses.
  logic [1:0]  guard, video;          // Per-socket controls.
  logic        bdn, bup, low, lock;   // Shared controls.
  logic [31:0] d;                     // Last read value.
  int          n_errors        = 0;   // Mismatches seen.
  int          samples_checked = 0;   // Comparisons made.

  // Rows: write, then read back through the same function.
  cbsc_row_t rows [5] = '{
    '{1'b0, 8'h80, 4'hf, 32'hffff_ffff, 32'h0030_d060, 8'h5f},
    '{1'b0, 8'h80, 4'hf, 32'h0000_0000, 32'h0000_1000, 8'h00},
    '{1'b1, 8'h80, 4'hf, 32'hffff_ffff, 32'h0030_1000, 8'ha0},
    '{1'b0, 8'h80, 4'h2, 32'hffff_ffff, 32'h0000_d000, 8'hac},
    '{1'b0, 8'h84, 4'hf, 32'hffff_ffff, 32'h0000_d000, 8'hac}};

  // The clock toggles every half period of 5 ns.
  always #5 sys_clk = ~sys_clk;

  cbsc_sysctl #(.UP_CYCLES(UP_N), .DN_CYCLES(DN_N)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .bus_reset_n(bus_reset_n),
    .pme_enable(pme_enable), .power_req(power_req), .power_up_dir(power_up_dir),
    .stream_done(stream_done), .probe_start(probe_start), .probe_done(probe_done),
    .card_access(card_access), .supply_guard_disable(guard), .reduced_video_pins(video),
    .read_burst_down_enable(bdn), .read_burst_up_enable(bup),
    .low_energy_enable(low), .id_write_lock(lock));

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One configuration read; the answer is due one cycle after the strobe.
  task automatic cfg_read(input logic func, input logic [7:0] addr);
    @(negedge sys_clk);
    cfg_func = func;
    cfg_addr = addr;
    cfg_rd   = 1'b1;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    chk({31'h0, cfg_rvalid}, 32'h1);
    d = cfg_rdata;
  endtask : cfg_read

  // One configuration write with the given byte lanes.
  task automatic cfg_write(input logic func, input logic [7:0] addr,
                           input logic [3:0] be, input logic [31:0] data);
    @(negedge sys_clk);
    cfg_func  = func;
    cfg_addr  = addr;
    cfg_be    = be;
    cfg_wdata = data;
    cfg_wr    = 1'b1;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask : cfg_write

  // Pulses one socket event for a single cycle.
  task automatic strobe(input int k, input int s);
    @(negedge sys_clk);
    case (k)
      0: power_req[s]   = 1'b1;
      1: stream_done[s] = 1'b1;
      2: probe_start[s] = 1'b1;
      3: probe_done[s]  = 1'b1;
      default: card_access[s] = 1'b1;
    endcase
    @(negedge sys_clk);
    {power_req, stream_done, probe_start, probe_done, card_access} = '0;
  endtask : strobe

  // Checks the image and the control outputs right after a global reset.
  task automatic check_reset;
    cfg_read(1'b0, 8'h80);
    chk(d, CBSC_SYSCTL_RESET & 32'h003f_ffe0);
    chk({24'h0, guard, video, bdn, bup, low, lock}, 32'h0000_000b);
  endtask : check_reset

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end

  // Main sequence: reset, table rows, then the awkward cases.
  initial begin
    repeat (20) @(negedge sys_clk);
    sys_rst = 1'b0;
    check_reset();
    foreach (rows[i]) begin
      cfg_write(rows[i].func, rows[i].addr, rows[i].be, rows[i].wdata);
      cfg_read(rows[i].func, 8'h80);
      chk(d, rows[i].image);
      chk({24'h0, guard, video, bdn, bup, low, lock}, {24'h0, rows[i].outs});
    end
    cfg_read(1'b0, 8'h84);
    chk(d, 32'h0);
    // Activity flag sets on access and clears only on a read through its own function.
    strobe(4, 0);
    cfg_read(1'b1, 8'h80);
    chk({31'h0, d[13]}, 32'h0);
    cfg_read(1'b0, 8'h80);
    chk({31'h0, d[13]}, 32'h1);
    cfg_read(1'b0, 8'h80);
    chk({31'h0, d[13]}, 32'h0);
    // Two reads back to back: the second sees the flag cleared.
    strobe(4, 1);
    @(negedge sys_clk);
    cfg_func = 1'b1;
    cfg_rd   = 1'b1;
    @(negedge sys_clk);
    chk({30'h0, cfg_rvalid, cfg_rdata[13]}, 32'h3);
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    chk({30'h0, cfg_rvalid, cfg_rdata[13]}, 32'h2);
    @(negedge sys_clk);
    chk({31'h0, cfg_rvalid}, 32'h0);
    // Socket 0 powers up, socket 1 powers down.
    for (int s = 0; s < 2; s++) begin
      power_up_dir[s] = (s == 0);
      strobe(0, s);
      cfg_read(s[0], 8'h80);
      chk({28'h0, d[11:8]}, 32'h8);
      strobe(1, s);
      cfg_read(s[0], 8'h80);
      chk({28'h0, d[11:8]}, (s == 0) ? 32'hc : 32'ha);
      repeat (UP_N) @(negedge sys_clk);
      cfg_read(s[0], 8'h80);
      chk({28'h0, d[11:8]}, 32'h0);
    end
    // Probe flag follows start and end on socket 1.
    strobe(2, 1);
    cfg_read(1'b1, 8'h80);
    chk({31'h0, d[8]}, 32'h1);
    strobe(3, 1);
    cfg_read(1'b1, 8'h80);
    chk({31'h0, d[8]}, 32'h0);
    // Bus reset keeps sticky bits and clears context bits only without events.
    strobe(2, 0);
    cfg_write(1'b0, 8'h80, 4'hf, 32'h0020_0000);
    for (int p = 1; p >= 0; p--) begin
      pme_enable  = p[0];
      bus_reset_n = 1'b0;
      repeat (6) @(negedge sys_clk);
      bus_reset_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      cfg_read(1'b0, 8'h80);
      chk({30'h0, d[21], d[8]}, {30'h0, 1'b1, p[0]});
    end
    // A global reset in mid-run restores every default.
    sys_rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    check_reset();
    stop_test();
  end

endmodule : test_cbsc_sysctl
